/* File: aopms_pkg.sv */
package aopms_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam logic [7:0]  RESULT_OFS      = 8'h08;
  localparam logic [7:0]  ADDR_MASK       = 8'hFC;

  // ==========================================================================
  // Control fields
  // ==========================================================================
  localparam int          CTRL_BYTE_ORDER = 0;
  localparam int          CTRL_CODING     = 1;
  localparam int          CTRL_IFACE      = 2;
  localparam int          CTRL_CLK_SRC    = 3;
  localparam int          CTRL_RD_TIMING  = 4;
  localparam int          CTRL_W          = 5;
  // Straight binary, little byte order, parallel, master, read after convert
  localparam logic [4:0]  CTRL_RESET      = 5'h02;

  // ==========================================================================
  // Status fields
  // ==========================================================================
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_DIV_LSB    = 2;
  localparam int          STAT_PEND       = 4;
  localparam int          STAT_MASTER     = 5;
  localparam int          STAT_CNT_LSB    = 6;

  // ==========================================================================
  // Data and timing
  // ==========================================================================
  localparam int          RESULT_W        = 16;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          SCLK_HIGH_MIN_NS = 15;
  // Least time rounds up to whole cycles
  localparam int          SCLK_HALF_CYC   = (SCLK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DIV_CNT_W       = 5;

  typedef enum logic [1:0] {
    AOPMS_IDLE  = 2'b00,
    AOPMS_SHIFT = 2'b01,
    AOPMS_DONE  = 2'b11
  } aopms_state_e;

endpackage

/* File: aopms_clk_div.sv */
`timescale 1ns/1ps
module aopms_clk_div
  import aopms_pkg::*;
#(
  parameter int CNT_W = DIV_CNT_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] half_cycles,
  output logic                  tick
);

  // ==========================================================================
  // Half-period counter
  // ==========================================================================
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_tick;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt == half_cycles - CNT_W'(1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule // aopms_clk_div

/* File: aopms_output_port.sv */
`timescale 1ns/1ps
// Function
// - Byte order high: low byte on top
// - Byte order low: low byte on bottom
// - Coding high: straight binary, unaltered
// - Coding low: invert MSB, twos complement
// - Interface low: parallel data port
// - Interface high: serial, other pins released
// - Pins 0 and 1 always drive bits
// - Parallel: pins 2 to 15 drive bits
// - Other serial modes: divide pins released, ignored
// - Source low: master drives serial clock
// - Source high: shift on host clock, gated
// - Divide codes slow clock by 1,2,4,8
// - Read timing low after, high during, master only; source high always reads after
module aopms_output_port
  import aopms_pkg::*;
#(
  parameter int DATA_W = RESULT_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [DATA_W-1:0] result_in,
  input  wire logic              result_valid,
  input  wire logic              conv_start,
  input  wire logic              cs_n,
  input  wire logic [DATA_W-1:0] d_in,
  output logic      [DATA_W-1:0] d_out,
  output logic      [DATA_W-1:0] d_oe,
  input  wire logic              serial_data_clk_in,
  output logic                   serial_data_clk_out,
  output logic                   serial_data_clk_oe,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [31:0]       next_prdata;
  logic [DATA_W-1:0] cur_res;
  logic [DATA_W-1:0] next_cur_res;
  logic [DATA_W-1:0] par_word;
  logic [DATA_W-1:0] next_par_word;
  logic [DATA_W-1:0] coded_res;
  logic              apb_wr;
  logic              apb_setup;
  logic              addr_ok;

  logic              byte_order_sel;
  logic              output_coding_sel;
  logic              interface_type_sel;
  logic              serial_clk_source_sel;
  logic              read_timing_sel;

  aopms_state_e      state;
  aopms_state_e      next_state;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] next_shreg;
  logic [4:0]        bit_cnt;
  logic [4:0]        next_bit_cnt;
  logic              sclk_lvl;
  logic              next_sclk_lvl;
  logic              pend;
  logic              next_pend;
  logic [DATA_W-1:0] pend_data;
  logic [DATA_W-1:0] next_pend_data;
  logic              master_frame;
  logic              next_master_frame;
  logic [1:0]        serial_clk_divide;
  logic [1:0]        next_serial_clk_divide;
  logic              ext_clk_q;
  logic              ext_rise;
  logic              load_ev;
  logic [DATA_W-1:0] load_data;
  logic              start;
  logic              tick;
  logic [DIV_CNT_W-1:0] half_cycles;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  assign byte_order_sel        = ctrl[CTRL_BYTE_ORDER];
  assign output_coding_sel     = ctrl[CTRL_CODING];
  assign interface_type_sel    = ctrl[CTRL_IFACE];
  assign serial_clk_source_sel = ctrl[CTRL_CLK_SRC];
  assign read_timing_sel       = ctrl[CTRL_RD_TIMING];

  // Coding is applied before the swap; the serial port and RESULT read get the coded word unswapped
  function automatic logic [DATA_W-1:0] fmt(input logic [DATA_W-1:0] r, input logic coding);
    logic [DATA_W-1:0] f;
    f = r;
    f[DATA_W-1] = r[DATA_W-1] ^ ~coding;
    return f;
  endfunction

  // ==========================================================================
  // APB slave
  // ==========================================================================
  // Zero wait states: read data are registered in the setup cycle
  assign pready    = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign addr_ok   = ((paddr & ADDR_MASK) == CTRL_OFS) ||
                     ((paddr & ADDR_MASK) == STATUS_OFS) ||
                     ((paddr & ADDR_MASK) == RESULT_OFS);
  assign pslverr   = psel & penable & ~addr_ok;

  always_comb begin
    next_ctrl   = ctrl;
    next_prdata = prdata;
    if (apb_wr && (paddr & ADDR_MASK) == CTRL_OFS) begin
      next_ctrl = pwdata[CTRL_W-1:0];
    end
    if (apb_setup) begin
      if ((paddr & ADDR_MASK) == CTRL_OFS) begin
        next_prdata = {27'h0, ctrl};
      end else if ((paddr & ADDR_MASK) == STATUS_OFS) begin
        next_prdata = 32'h00000000;
        next_prdata[STAT_STATE_LSB +: 2] = state;
        next_prdata[STAT_DIV_LSB +: 2]   = serial_clk_divide;
        next_prdata[STAT_PEND]           = pend;
        next_prdata[STAT_MASTER]         = master_frame;
        next_prdata[STAT_CNT_LSB +: 5]   = bit_cnt;
      end else if ((paddr & ADDR_MASK) == RESULT_OFS) begin
        next_prdata = {16'h0000, fmt(cur_res, output_coding_sel)};
      end else begin
        next_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= CTRL_RESET;
      prdata <= 32'h00000000;
    end else begin
      ctrl   <= next_ctrl;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Result capture and parallel word
  // ==========================================================================
  always_comb begin
    next_cur_res  = cur_res;
    if (result_valid) begin
      next_cur_res = result_in;
    end
    coded_res = fmt(next_cur_res, output_coding_sel);
    if (byte_order_sel) begin
      next_par_word = {coded_res[DATA_W/2-1:0], coded_res[DATA_W-1:DATA_W/2]};
    end else begin
      next_par_word = coded_res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_res  <= '0;
      par_word <= '0;
    end else begin
      cur_res  <= next_cur_res;
      par_word <= next_par_word;
    end
  end

  // ==========================================================================
  // Data bus pins
  // ==========================================================================
  always_comb begin
    d_out = par_word;
    d_oe  = '0;
    d_oe[1:0] = 2'b11;
    if (!interface_type_sel) begin
      d_oe = '1;
    end else begin
      d_oe[DATA_W-1:2] = '0;
    end
  end

  // ==========================================================================
  // Serial clock source
  // ==========================================================================
  // Half period of 2 cycles gives a 40 ns period, inside the 30 to 45 ns window
  assign half_cycles = DIV_CNT_W'(SCLK_HALF_CYC) << serial_clk_divide;

  aopms_clk_div #(
    .CNT_W       (DIV_CNT_W)
  ) u_clk_div (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (state == AOPMS_SHIFT && master_frame),
    .half_cycles (half_cycles),
    .tick        (tick)
  );

  // Pins are synchronous, one flop is enough for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_q <= 1'b0;
    end else begin
      ext_clk_q <= serial_data_clk_in;
    end
  end
  assign ext_rise = serial_data_clk_in & ~ext_clk_q;

  // ==========================================================================
  // Serial load event
  // ==========================================================================
  always_comb begin
    load_ev   = 1'b0;
    load_data = cur_res;
    if (serial_clk_source_sel) begin
      load_ev   = result_valid;
      load_data = result_in;
    end else if (read_timing_sel) begin
      load_ev   = conv_start;
      load_data = cur_res;
    end else begin
      load_ev   = result_valid;
      load_data = result_in;
    end
  end

  // Clock source, divide and coding are frozen per frame and change at the next start; pin enables follow ctrl at once
  assign start = interface_type_sel & pend & ~cs_n & (state == AOPMS_IDLE);

  // ==========================================================================
  // Serial shifter
  // ==========================================================================
  always_comb begin
    next_state             = state;
    next_shreg             = shreg;
    next_bit_cnt           = bit_cnt;
    next_sclk_lvl          = sclk_lvl;
    next_pend              = pend;
    next_pend_data         = pend_data;
    next_master_frame      = master_frame;
    next_serial_clk_divide = serial_clk_divide;
    if (start) begin
      next_pend = 1'b0;
    end
    // A new result arriving with the start is kept, not lost
    if (load_ev) begin
      next_pend      = 1'b1;
      next_pend_data = load_data;
    end
    case (state)
      AOPMS_IDLE: begin
        next_sclk_lvl = 1'b0;
        if (start) begin
          next_state        = AOPMS_SHIFT;
          next_shreg        = fmt(pend_data, output_coding_sel);
          next_bit_cnt      = 5'h00;
          next_master_frame = ~serial_clk_source_sel;
          if (!serial_clk_source_sel && !read_timing_sel) begin
            next_serial_clk_divide = {d_in[3], d_in[2]};
          end else begin
            next_serial_clk_divide = 2'h0;
          end
        end
      end
      AOPMS_SHIFT: begin
        if (cs_n) begin
          next_state    = AOPMS_IDLE;
          next_sclk_lvl = 1'b0;
        end else if (master_frame) begin
          if (tick) begin
            next_sclk_lvl = ~sclk_lvl;
            if (sclk_lvl) begin
              next_shreg   = {shreg[DATA_W-2:0], 1'b0};
              next_bit_cnt = bit_cnt + 5'h01;
              if (bit_cnt == 5'(DATA_W - 1)) begin
                next_state = AOPMS_DONE;
              end
            end
          end
        end else if (ext_rise) begin
          next_shreg   = {shreg[DATA_W-2:0], 1'b0};
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == 5'(DATA_W - 1)) begin
            next_state = AOPMS_DONE;
          end
        end
      end
      AOPMS_DONE: begin
        next_sclk_lvl = 1'b0;
        if (cs_n) begin
          next_state = AOPMS_IDLE;
        end
      end
      default: begin
        next_state = AOPMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= AOPMS_IDLE;
      shreg             <= '0;
      bit_cnt           <= 5'h00;
      sclk_lvl          <= 1'b0;
      pend              <= 1'b0;
      pend_data         <= '0;
      master_frame      <= 1'b0;
      serial_clk_divide <= 2'h0;
    end else begin
      state             <= next_state;
      shreg             <= next_shreg;
      bit_cnt           <= next_bit_cnt;
      sclk_lvl          <= next_sclk_lvl;
      pend              <= next_pend;
      pend_data         <= next_pend_data;
      master_frame      <= next_master_frame;
      serial_clk_divide <= next_serial_clk_divide;
    end
  end

  // ==========================================================================
  // Serial pins
  // ==========================================================================
  // Master data change on the falling edge so the host samples on the rising one; on the host clock data shift at its rising edge
  assign serial_data_out     = shreg[DATA_W-1];
  assign serial_data_out_oe  = interface_type_sel & ~cs_n;
  assign serial_data_clk_out = sclk_lvl;
  assign serial_data_clk_oe  = interface_type_sel & ~serial_clk_source_sel & ~cs_n;

endmodule // aopms_output_port

/* File: aopms_output_port_asserts.sv */
`timescale 1ns/1ps
// ====================
// Port checks
module aopms_output_port_asserts
  import aopms_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] d_oe,
  input wire logic        serial_data_clk_out,
  input wire logic        serial_data_clk_oe,
  input wire logic        serial_data_out_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_low_pins_out: assert property (d_oe[1:0] == 2'b11)
    else $error("low data pins released");
  a_oe_mode_shape: assert property (d_oe == 16'hFFFF || d_oe == 16'h0003)
    else $error("data bus enables fit no mode");
  a_sdo_serial_only: assert property (serial_data_out_oe |-> d_oe == 16'h0003)
    else $error("serial output while bus driven");
  a_master_clk_pin: assert property (serial_data_clk_oe |-> d_oe == 16'h0003)
    else $error("clock driven outside serial mode");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase stalled");
  // Two cycles high and low is the shortest legal half period
  a_sclk_high_min: assert property ($rose(serial_data_clk_out) |-> serial_data_clk_out [*2])
    else $error("serial clock high too short");
  a_sclk_low_min: assert property ($fell(serial_data_clk_out) |-> !serial_data_clk_out [*2])
    else $error("serial clock low too short");
endmodule // aopms_output_port_asserts

bind aopms_output_port aopms_output_port_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .d_oe(d_oe), .serial_data_clk_out(serial_data_clk_out),
  .serial_data_clk_oe(serial_data_clk_oe), .serial_data_out_oe(serial_data_out_oe));

/* File: aopms_host_model.sv */
`timescale 1ns/1ps
// ====================
// Host reading results
module aopms_host_model (
  input  wire logic        pclk,
  input  wire logic        serial_data_clk_out,
  input  wire logic        serial_data_out,
  output logic             cs_n,
  output logic             serial_data_clk_in,
  output logic [15:0]      d_in
);
  logic [1:0]  div;
  logic [11:0] noise;
  // Unused pins move every cycle so a stale value never passes
  assign d_in = {noise, div, noise[1:0]};

  initial begin
    cs_n = 1'b1;
    serial_data_clk_in = 1'b0;
    div = 2'b00;
    noise = 12'h000;
  end

  always @(posedge pclk) noise <= noise + 12'h001;

  // Clock stands still low outside frames
  task automatic frame(input logic slave, input logic [1:0] dv, output logic [15:0] word, output int per);
    time t0;
    word = 16'h0000;
    per = 0;
    t0 = 0;
    div <= dv;
    @(posedge pclk);
    cs_n <= 1'b0;
    if (slave) begin
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 16; i++) begin
        word = {word[14:0], serial_data_out};
        serial_data_clk_in <= 1'b1;
        repeat (2) @(posedge pclk);
        serial_data_clk_in <= 1'b0;
        repeat (2) @(posedge pclk);
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        while (serial_data_clk_out !== 1'b1) @(posedge pclk);
        word = {word[14:0], serial_data_out};
        if (i == 0) t0 = $time;
        if (i == 1) per = int'(($time - t0) / 10);
        while (serial_data_clk_out !== 1'b0) @(posedge pclk);
      end
    end
    cs_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
endmodule // aopms_host_model

/* File: aopms_output_port_tb.sv */
`timescale 1ns/1ps
// ====================
// Top bench
module aopms_output_port_tb
  import aopms_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, result_valid, conv_start, err;
  logic        pready, pslverr, cs_n, sclk_in, sclk_out, sclk_oe, sdo, sdo_oe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] result_in, d_in, d_out, d_oe, word;
  int          errors = 0, num_checks = 0, cyc = 0, per;

  aopms_output_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_in(result_in), .result_valid(result_valid), .conv_start(conv_start), .cs_n(cs_n), .d_in(d_in),
    .d_out(d_out), .d_oe(d_oe), .serial_data_clk_in(sclk_in), .serial_data_clk_out(sclk_out),
    .serial_data_clk_oe(sclk_oe), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe));
  aopms_host_model host (.pclk(pclk), .serial_data_clk_out(sclk_out), .serial_data_out(sdo), .cs_n(cs_n),
    .serial_data_clk_in(sclk_in), .d_in(d_in));

  // ====================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic load(input logic [15:0] r);
    result_in <= r;
    result_valid <= 1'b1;
    @(posedge pclk);
    result_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic [15:0] coded(input logic [15:0] r, input logic [4:0] c);
    logic [15:0] v;
    v = c[CTRL_CODING] ? r : {~r[15], r[14:0]};
    return c[CTRL_BYTE_ORDER] ? {v[7:0], v[15:8]} : v;
  endfunction

  // ====================
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ====================
  // Scenarios
  initial begin
    logic [15:0] r;
    logic [4:0]  c;
    {presetn, psel, penable, pwrite, result_valid, conv_start} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    result_in = 16'h0000;
    void'($urandom(35673));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, {27'h0, CTRL_RESET});
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Corner words 7FFF and 8000 first, then random ones
    for (int i = 0; i < 16; i++) begin
      c = {3'b000, i[1:0]};
      r = (i < 2) ? {i[0], {15{~i[0]}}} : 16'($urandom);
      apb(1'b1, CTRL_OFS, {27'h0, c});
      load(r);
      check({16'h0, d_out}, {16'h0, coded(r, c)});
      check({16'h0, d_oe}, 32'hFFFF);
      apb(1'b0, RESULT_OFS, 32'h0);
      check(rd, {16'h0, coded(r, {c[4:1], 1'b0})});
    end
    for (int i = 0; i < 4; i++) begin
      c = {3'b001, 2'($urandom)};
      apb(1'b1, CTRL_OFS, {27'h0, c});
      check({16'h0, d_oe}, 32'h0003);
      r = 16'($urandom);
      load(r);
      host.frame(1'b0, i[1:0], word, per);
      check({16'h0, word}, {16'h0, coded(r, {c[4:1], 1'b0})});
      check(per, 4 << i);
    end
    // Read during convert sends the previous word, divide pins ignored
    c = 5'h16;
    apb(1'b1, CTRL_OFS, {27'h0, c});
    r = 16'($urandom);
    load(r);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    load(~r);
    host.frame(1'b0, 2'b11, word, per);
    check({16'h0, word}, {16'h0, r});
    check(per, 4);
    c = 5'h0C;
    apb(1'b1, CTRL_OFS, {27'h0, c});
    r = 16'($urandom);
    load(r);
    host.frame(1'b1, 2'b11, word, per);
    check({16'h0, word}, {16'h0, coded(r, c)});
    check({31'h0, sclk_oe}, 32'h0);
    check({31'h0, sdo_oe}, 32'h0);
    give_verdict();
  end
endmodule // aopms_output_port_tb
